// ==== design/adc_chain_consts.svh ====
// Timing counts, widths and reset values for the converter chain logic.
`ifndef ADC_CHAIN_CONSTS_SVH
`define ADC_CHAIN_CONSTS_SVH

// ==========================================================================
// Widths and sizes
`define CHANNELS 4
`define SAMPLE_BITS 24
`define CODE_BITS 8
`define MAX_DEVICES 8
`define TOTAL_CHANNELS 32

// ==========================================================================
// Timing
`define CLOCK_PERIOD_NS 4
`define PHASE_STEP_NS 1330
`define PHASE_MAX_NS 333000
`define PHASE_MAX_CODE (`PHASE_MAX_NS / `PHASE_STEP_NS)
`define PHASE_STEP_CYCLES \
  ((`PHASE_STEP_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define FLAG_LATENCY_NS 200
`define FLAG_LATENCY_CYCLES \
  ((`FLAG_LATENCY_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define SAMPLE_HALF_CYCLES 50000

// ==========================================================================
// Reset values
`define PHASE_RESET 8'h00

`endif

// ==== design/adc_chain_pkg.sv ====
// Types shared by both ends of the converter chain link.
`include "adc_chain_consts.svh"

package adc_chain_pkg;
  typedef logic [`CODE_BITS-1:0] phase_code_type;
  typedef logic [`SAMPLE_BITS-1:0] sample_type;
  typedef logic [1:0] channel_index_type;
endpackage : adc_chain_pkg

// ==== design/adc_chain_if.sv ====
// Pin level link between one converter device and the surrounding system.
interface adc_chain_if;
  logic chain_in_n;
  logic chain_out_n;
  logic chain_data_ready_n;
  logic shared_clock_out;
  logic external_clock_in;
  logic range_exceeded_flag_n_o;
  logic range_exceeded_flag_n_oe_n;
  logic fault_flag_n_o;
  logic fault_flag_n_oe_n;
  logic latch_set_n;
  logic fault_line_n;

  // ========================================================================
  // Open-drain lines with pull-up; the wired-OR of more devices is the bench's.
  assign latch_set_n = range_exceeded_flag_n_oe_n ? 1'b1 :
                       range_exceeded_flag_n_o;
  assign fault_line_n = fault_flag_n_oe_n ? 1'b1 : fault_flag_n_o;

  modport device
  (
    input chain_in_n,
    input external_clock_in,
    output chain_out_n,
    output chain_data_ready_n,
    output shared_clock_out,
    output range_exceeded_flag_n_o,
    output range_exceeded_flag_n_oe_n,
    output fault_flag_n_o,
    output fault_flag_n_oe_n
  );

  modport host
  (
    output chain_in_n,
    output external_clock_in,
    input chain_data_ready_n,
    input latch_set_n,
    input fault_line_n
  );
endinterface : adc_chain_if

// ==== design/adc_chain_device.sv ====
// Converter device end: phase-delayed sampling, cascade handshake and flags.
module adc_chain_device
  import adc_chain_pkg::*;
#(
  parameter int SAMPLE_HALF_CYCLES = `SAMPLE_HALF_CYCLES
)
(
  input wire logic clock,
  input wire logic sys_rst,
  adc_chain_if.device link,
  input wire logic is_first,
  input wire logic [`CHANNELS*`SAMPLE_BITS-1:0] analog_sample,
  input wire logic over_range,
  input wire logic over_voltage,
  input wire logic phase_write,
  input wire channel_index_type phase_channel,
  input wire phase_code_type phase_code,
  input wire logic data_read,
  output logic [`CHANNELS*`SAMPLE_BITS-1:0] result,
  output logic data_ready,
  output logic sample_tick
);

  localparam logic [8:0] STEP_LAST = 9'(`PHASE_STEP_CYCLES - 1);
  localparam phase_code_type CODE_MAX = `CODE_BITS'(`PHASE_MAX_CODE);
  localparam logic [6:0] FLAG_LAST = 7'(`FLAG_LATENCY_CYCLES - 1);
  localparam logic [16:0] HALF_LAST = 17'(SAMPLE_HALF_CYCLES - 1);

  function automatic phase_code_type clamp_code(input phase_code_type c);
    clamp_code = (c > CODE_MAX) ? CODE_MAX : c;
  endfunction : clamp_code

  // ========================================================================
  // Timebase: own divider or the shared clock from the first device
  logic [16:0] half_cnt_r;
  logic [16:0] half_cnt_nxt;
  logic clk_out_r;
  logic clk_out_nxt;
  logic ext_meta_r;
  logic ext_sync_r;
  logic ext_prev_r;
  logic tick_r;
  logic tick_nxt;

  always_comb
  begin
    half_cnt_nxt = half_cnt_r - 17'h00001;
    clk_out_nxt = clk_out_r;
    tick_nxt = 1'b0;
    if (half_cnt_r == 17'h00000)
    begin
      half_cnt_nxt = HALF_LAST;
      clk_out_nxt = ~clk_out_r;
    end
    if (is_first)
      tick_nxt = (half_cnt_r == 17'h00000) && !clk_out_r;
    else
      tick_nxt = ext_sync_r && !ext_prev_r;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      half_cnt_r <= 17'h00000;
      clk_out_r <= 1'b0;
      ext_meta_r <= 1'b0;
      ext_sync_r <= 1'b0;
      ext_prev_r <= 1'b0;
      tick_r <= 1'b0;
    end
    else
    begin
      half_cnt_r <= half_cnt_nxt;
      clk_out_r <= clk_out_nxt;
      ext_meta_r <= link.external_clock_in;
      ext_sync_r <= ext_meta_r;
      ext_prev_r <= ext_sync_r;
      tick_r <= tick_nxt;
    end
  end

  assign link.shared_clock_out = clk_out_r;
  assign sample_tick = tick_r;

  // ========================================================================
  // Phase delay settings and per-channel sampling
  phase_code_type code_r [`CHANNELS];
  phase_code_type code_nxt [`CHANNELS];
  phase_code_type remain_r [`CHANNELS];
  phase_code_type remain_nxt [`CHANNELS];
  logic [8:0] step_r [`CHANNELS];
  logic [8:0] step_nxt [`CHANNELS];
  logic [`CHANNELS-1:0] busy_r;
  logic [`CHANNELS-1:0] busy_nxt;
  logic [`CHANNELS-1:0] done_r;
  logic [`CHANNELS-1:0] done_nxt;
  logic [`CHANNELS*`SAMPLE_BITS-1:0] result_r;
  logic [`CHANNELS*`SAMPLE_BITS-1:0] result_nxt;
  logic ready_r;
  logic ready_nxt;
  logic all_done;

  always_comb
  begin
    result_nxt = result_r;
    busy_nxt = busy_r;
    done_nxt = done_r;
    for (int ch = 0; ch < `CHANNELS; ch++)
    begin
      code_nxt[ch] = code_r[ch];
      remain_nxt[ch] = remain_r[ch];
      step_nxt[ch] = step_r[ch];
      if (phase_write && (phase_channel == 2'(ch)))
        code_nxt[ch] = clamp_code(phase_code);
      if (tick_r)
      begin
        done_nxt[ch] = 1'b0;
        if (code_r[ch] == `PHASE_RESET)
        begin
          result_nxt[ch*`SAMPLE_BITS +: `SAMPLE_BITS] =
            analog_sample[ch*`SAMPLE_BITS +: `SAMPLE_BITS];
          done_nxt[ch] = 1'b1;
          busy_nxt[ch] = 1'b0;
        end
        else
        begin
          remain_nxt[ch] = code_r[ch];
          step_nxt[ch] = STEP_LAST;
          busy_nxt[ch] = 1'b1;
        end
      end
      else if (busy_r[ch])
      begin
        if (step_r[ch] != 9'h000)
          step_nxt[ch] = step_r[ch] - 9'h001;
        else if (remain_r[ch] == 8'h01)
        begin
          result_nxt[ch*`SAMPLE_BITS +: `SAMPLE_BITS] =
            analog_sample[ch*`SAMPLE_BITS +: `SAMPLE_BITS];
          done_nxt[ch] = 1'b1;
          busy_nxt[ch] = 1'b0;
        end
        else
        begin
          remain_nxt[ch] = remain_r[ch] - 8'h01;
          step_nxt[ch] = STEP_LAST;
        end
      end
    end
    // A frame whose channels all capture at the tick completes at once.
    all_done = (&done_nxt) && (tick_r || !(&done_r));
    // A fresh completion wins over a read in the same cycle.
    ready_nxt = all_done ? 1'b1 : (tick_r || data_read) ? 1'b0 : ready_r;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      for (int ch = 0; ch < `CHANNELS; ch++)
      begin
        code_r[ch] <= `PHASE_RESET;
        remain_r[ch] <= 8'h00;
        step_r[ch] <= 9'h000;
      end
      busy_r <= 4'h0;
      done_r <= 4'h0;
      result_r <= '0;
      ready_r <= 1'b0;
    end
    else
    begin
      code_r <= code_nxt;
      remain_r <= remain_nxt;
      step_r <= step_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      result_r <= result_nxt;
      ready_r <= ready_nxt;
    end
  end

  assign result = result_r;
  assign data_ready = ready_r;

  // ========================================================================
  // Cascade handshake
  logic chain_meta_r;
  logic chain_sync_r;
  logic chain_out_r;
  logic chain_out_nxt;

  always_comb
  begin
    chain_out_nxt = !(ready_r && !chain_sync_r);
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      chain_meta_r <= 1'b1;
      chain_sync_r <= 1'b1;
      chain_out_r <= 1'b1;
    end
    else
    begin
      chain_meta_r <= link.chain_in_n;
      chain_sync_r <= chain_meta_r;
      chain_out_r <= chain_out_nxt;
    end
  end

  assign link.chain_out_n = chain_out_r;
  assign link.chain_data_ready_n = chain_out_r;

  // ========================================================================
  // Overflow and fault flags with matched latency
  logic [1:0] cond;
  logic [1:0] flag_r;
  logic [1:0] flag_nxt;
  logic [6:0] lat_r [2];
  logic [6:0] lat_nxt [2];

  always_comb
  begin
    cond = {over_voltage, over_range};
    for (int f = 0; f < 2; f++)
    begin
      flag_nxt[f] = flag_r[f];
      lat_nxt[f] = 7'h00;
      if (cond[f] != flag_r[f])
      begin
        lat_nxt[f] = lat_r[f] + 7'h01;
        if (lat_r[f] == FLAG_LAST)
        begin
          flag_nxt[f] = cond[f];
          lat_nxt[f] = 7'h00;
        end
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      flag_r <= 2'h0;
      lat_r[0] <= 7'h00;
      lat_r[1] <= 7'h00;
    end
    else
    begin
      flag_r <= flag_nxt;
      lat_r <= lat_nxt;
    end
  end

  assign link.range_exceeded_flag_n_o = 1'b0;
  assign link.range_exceeded_flag_n_oe_n = !flag_r[0];
  assign link.fault_flag_n_o = 1'b0;
  assign link.fault_flag_n_oe_n = !flag_r[1];

endmodule : adc_chain_device

// ==== design/adc_chain_host.sv ====
// System end: chain wiring, shared clock feed and interrupt latches.
module adc_chain_host
  import adc_chain_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  adc_chain_if.host link,
  input wire logic upstream_ready_n,
  input wire logic first_clock,
  input wire logic read_strobe_n,
  output logic chain_ready,
  output logic overflow_irq,
  output logic fault_irq
);

  // ========================================================================
  // Chain and clock feed
  // upstream output to this input
  assign link.chain_in_n = upstream_ready_n;
  assign link.external_clock_in = first_clock;

  // ========================================================================
  // Synchronisers and latches
  logic [2:0] meta_r;
  logic [2:0] sync_r;
  logic [1:0] prev_r;
  logic [1:0] irq_r;
  logic [1:0] irq_nxt;
  logic ready_r;

  always_comb
  begin
    for (int f = 0; f < 2; f++)
    begin
      if (!sync_r[f] && prev_r[f])
        irq_nxt[f] = 1'b1;
      else if (!read_strobe_n)
        irq_nxt[f] = 1'b0;
      else
        irq_nxt[f] = irq_r[f];
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      meta_r <= 3'h7;
      sync_r <= 3'h7;
      prev_r <= 2'h3;
      irq_r <= 2'h0;
      ready_r <= 1'b0;
    end
    else
    begin
      meta_r <= {link.chain_data_ready_n, link.fault_line_n,
                 link.latch_set_n};
      sync_r <= meta_r;
      prev_r <= sync_r[1:0];
      irq_r <= irq_nxt;
      ready_r <= !sync_r[2];
    end
  end

  assign chain_ready = ready_r;
  assign overflow_irq = irq_r[0];
  assign fault_irq = irq_r[1];

endmodule : adc_chain_host

// ==== verification/adc_chain_props.sv ====
// Concurrent checks on the pin level converter chain link.
module adc_chain_props
#(
  parameter int SAMPLE_HALF_CYCLES = 1000
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic chain_in_n,
  input wire logic chain_out_n,
  input wire logic chain_data_ready_n,
  input wire logic shared_clock_out,
  input wire logic range_exceeded_flag_n_o,
  input wire logic range_exceeded_flag_n_oe_n,
  input wire logic fault_flag_n_o,
  input wire logic fault_flag_n_oe_n,
  input wire logic latch_set_n,
  input wire logic fault_line_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int half_cnt_r;
  logic last_clk_r;
  logic armed_r;

  // ==========================================================================
  // Half period counter
  // The first toggle after reset has no earlier edge, so it is not judged.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      half_cnt_r <= 0;
      armed_r <= 1'b0;
    end
    else
    begin
      half_cnt_r <= (shared_clock_out != last_clk_r) ? 0 : half_cnt_r + 1;
      armed_r <= armed_r | (shared_clock_out != last_clk_r);
    end
    last_clk_r <= sys_rst ? 1'b0 : shared_clock_out;
  end

  // ==========================================================================
  // Properties
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_up_idle;
    chain_in_n;
  endsequence
  sequence s_out_idle;
    ##3 chain_out_n;
  endsequence
  property p_chain_idle;
    s_up_idle |-> s_out_idle;
  endproperty
  property p_ready_mirror;
    chain_data_ready_n == chain_out_n;
  endproperty
  property p_over_drive;
    !range_exceeded_flag_n_oe_n |-> !range_exceeded_flag_n_o;
  endproperty
  property p_fault_drive;
    !fault_flag_n_oe_n |-> !fault_flag_n_o;
  endproperty
  property p_over_line;
    latch_set_n == (range_exceeded_flag_n_oe_n | range_exceeded_flag_n_o);
  endproperty
  property p_half_period;
    (armed_r && shared_clock_out != last_clk_r) |->
      half_cnt_r == SAMPLE_HALF_CYCLES - 1;
  endproperty
  property p_over_hold;
    $fell(range_exceeded_flag_n_oe_n) |->
      !range_exceeded_flag_n_oe_n throughout (##49 1'b1);
  endproperty
  property p_fault_hold;
    $fell(fault_flag_n_oe_n) |-> !fault_flag_n_oe_n throughout (##49 1'b1);
  endproperty
  a_chain_idle: assert property (p_chain_idle)
    else $error("chain output low while upstream not ready");
  a_ready_mirror: assert property (p_ready_mirror)
    else $error("data ready pin differs from chain output");
  a_over_drive: assert property (p_over_drive)
    else $error("overflow pin driven high");
  a_fault_drive: assert property (p_fault_drive)
    else $error("fault pin driven high");
  a_over_line: assert property (p_over_line)
    else $error("overflow line level wrong");
  a_half_period: assert property (p_half_period)
    else $error("shared clock half period wrong");
  a_over_hold: assert property (p_over_hold)
    else $error("overflow flag released too soon");
  a_fault_hold: assert property (p_fault_hold)
    else $error("fault flag released too soon");
endmodule : adc_chain_props

// ==== verification/adc_cascade_phase_fault_logic_test.sv ====
// Bench joining the device end and the system end across the link.
`include "adc_chain_consts.svh"
module adc_cascade_phase_fault_logic_test
  import adc_chain_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 1000;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [95:0] analog_sample = '0;
  logic over_range = 1'b0;
  logic over_voltage = 1'b0;
  logic phase_write = 1'b0;
  channel_index_type phase_channel = 2'h0;
  phase_code_type phase_code = 8'h00;
  logic data_read = 1'b0;
  logic upstream_ready_n = 1'b1;
  logic read_strobe_n = 1'b1;
  logic is_first = 1'b1;
  logic shared_clock;
  logic [95:0] result;
  logic data_ready, sample_tick, chain_ready, overflow_irq, fault_irq;
  int miscompares = 0;
  int n_compared = 0;
  adc_chain_if link ();

  assign shared_clock = link.shared_clock_out;

  adc_chain_device #(.SAMPLE_HALF_CYCLES(HALF)) u_adc_chain_device
  (
    .clock(clock), .sys_rst(sys_rst), .link(link), .is_first(is_first),
    .analog_sample(analog_sample), .over_range(over_range),
    .over_voltage(over_voltage), .phase_write(phase_write),
    .phase_channel(phase_channel), .phase_code(phase_code),
    .data_read(data_read), .result(result), .data_ready(data_ready),
    .sample_tick(sample_tick)
  );
  adc_chain_host u_adc_chain_host
  (
    .clock(clock), .sys_rst(sys_rst), .link(link),
    .upstream_ready_n(upstream_ready_n),
    .first_clock(link.shared_clock_out), .read_strobe_n(read_strobe_n),
    .chain_ready(chain_ready), .overflow_irq(overflow_irq),
    .fault_irq(fault_irq)
  );
  adc_chain_props #(.SAMPLE_HALF_CYCLES(HALF)) u_adc_chain_props
  (
    .clock(clock), .sys_rst(sys_rst), .chain_in_n(link.chain_in_n),
    .chain_out_n(link.chain_out_n),
    .chain_data_ready_n(link.chain_data_ready_n),
    .shared_clock_out(link.shared_clock_out),
    .range_exceeded_flag_n_o(link.range_exceeded_flag_n_o),
    .range_exceeded_flag_n_oe_n(link.range_exceeded_flag_n_oe_n),
    .fault_flag_n_o(link.fault_flag_n_o),
    .fault_flag_n_oe_n(link.fault_flag_n_oe_n),
    .latch_set_n(link.latch_set_n), .fault_line_n(link.fault_line_n)
  );

  initial
  begin
    forever #2 clock = ~clock;
  end

  // ==========================================================================
  // Shared tasks
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk1

  task automatic chk96(input logic [95:0] got, input logic [95:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk96

  // A wait that runs out counts as a mismatch and ends the run.
  task automatic wait_for(ref logic sig, input logic lvl, input int bound);
    int n;
    n = 0;
    while (sig !== lvl)
    begin
      @(negedge clock);
      n++;
      if (n > bound)
      begin
        miscompares++;
        tally_and_finish();
      end
    end
  endtask : wait_for

  // ==========================================================================
  // Scenarios
  task automatic run_frame(input bit wr, input int c [4]);
    logic [95:0] exp;
    for (int k = 0; k < 4; k++)
      exp[k*24+:24] = 24'(c[k] * `PHASE_STEP_CYCLES) ^ 24'hA5A5A5;
    wait_for(sample_tick, 1'b1, 2 * HALF + 10);
    @(negedge clock);
    for (int k = 0; k < 4 && wr; k++)
    begin
      phase_write = 1'b1;
      phase_channel = 2'(k);
      phase_code = 8'(c[k]);
      @(negedge clock);
    end
    phase_write = 1'b0;
    wait_for(sample_tick, 1'b1, 2 * HALF + 10);
    for (int i = 0; i <= 3 * `PHASE_STEP_CYCLES + 1; i++)
    begin
      analog_sample = {4{24'(i) ^ 24'hA5A5A5}};
      @(negedge clock);
    end
    wait_for(data_ready, 1'b1, 10);
    chk96(result, exp);
  endtask : run_frame

  task automatic s_chain();
    chk1(link.chain_data_ready_n, 1'b1);
    upstream_ready_n = 1'b0;
    wait_for(chain_ready, 1'b1, 10);
    chk1(link.chain_data_ready_n, 1'b0);
    data_read = 1'b1;
    @(negedge clock);
    data_read = 1'b0;
    @(negedge clock);
    chk1(data_ready, 1'b0);
    wait_for(chain_ready, 1'b0, 10);
  endtask : s_chain

  task automatic s_flags();
    over_range = 1'b1;
    repeat (20) @(negedge clock);
    over_range = 1'b0;
    repeat (60) @(negedge clock);
    chk1(overflow_irq, 1'b0);
    over_range = 1'b1;
    over_voltage = 1'b1;
    repeat (45) @(negedge clock);
    chk1(link.latch_set_n & link.fault_line_n, 1'b1);
    repeat (10) @(negedge clock);
    chk1(link.latch_set_n, 1'b0);
    chk1(link.fault_line_n, 1'b0);
    over_range = 1'b0;
    over_voltage = 1'b0;
    repeat (60) @(negedge clock);
    chk1(link.latch_set_n & link.fault_line_n, 1'b1);
    chk1(overflow_irq & fault_irq, 1'b1);
    read_strobe_n = 1'b0;
    @(negedge clock);
    read_strobe_n = 1'b1;
    @(negedge clock);
    chk1(overflow_irq | fault_irq, 1'b0);
  endtask : s_flags

  // A following device takes its tick from the clock pin, three edges late.
  task automatic s_follow();
    is_first = 1'b0;
    wait_for(shared_clock, 1'b0, 2 * HALF + 10);
    wait_for(shared_clock, 1'b1, 2 * HALF + 10);
    chk1(sample_tick, 1'b0);
    repeat (2) @(negedge clock);
    chk1(sample_tick, 1'b0);
    @(negedge clock);
    chk1(sample_tick, 1'b1);
    @(negedge clock);
    chk1(sample_tick, 1'b0);
  endtask : s_follow

  initial
  begin
    repeat (2) @(negedge clock);
    sys_rst = 1'b0;
    chk96(result, 96'h0);
    chk1(link.chain_out_n, 1'b1);
    run_frame(1'b0, '{0, 0, 0, 0});
    s_chain();
    run_frame(1'b1, '{3, 0, 2, 1});
    s_flags();
    s_follow();
    tally_and_finish();
  end
endmodule : adc_cascade_phase_fault_logic_test
